/* verilog/cgpdc_map.svh */
`ifndef CGPDC_MAP_SVH
`define CGPDC_MAP_SVH
// ****************************************************************
// register byte addresses, page in the high byte
// ****************************************************************
`define CGPDC_ADDR_SOFT 16'h001C
`define CGPDC_ADDR_PDN 16'h001E
`define CGPDC_ADDR_DRV0A 16'h0103
`define CGPDC_ADDR_DRV0 16'h0108
`define CGPDC_ADDR_DRV1 16'h010D
`define CGPDC_ADDR_DRV2 16'h0112
`define CGPDC_ADDR_DRV3 16'h0117
`define CGPDC_ADDR_DRV4 16'h011C
`define CGPDC_ADDR_DRV5 16'h0121
`define CGPDC_ADDR_DRV6 16'h0126
`define CGPDC_ADDR_DRV7 16'h012B
`define CGPDC_ADDR_DRV8 16'h0130
`define CGPDC_ADDR_DRV9 16'h0135
`define CGPDC_ADDR_DRV9A 16'h013A
`define CGPDC_ADDR_ALL 16'h0145
`define CGPDC_ADDR_OSC 16'h090E
`define CGPDC_ADDR_REFF 16'h0940
`define CGPDC_ADDR_IOCFG 16'h0941
`define CGPDC_PAGE_LOC 8'h01
`define CGPDC_N_DRV 12
// ****************************************************************
// field positions
// ****************************************************************
`define CGPDC_BIT_SOFT 0
`define CGPDC_BIT_DEVPDN 0
`define CGPDC_BIT_HARD 1
`define CGPDC_BIT_DRV 0
`define CGPDC_BIT_ALL 0
`define CGPDC_BIT_OSC 1
`define CGPDC_BIT_IO1V8 0
`define CGPDC_BIT_XTAL 1
// ****************************************************************
// reset and blank-image values
// ****************************************************************
`define CGPDC_RST_PAGE 8'h00
`define CGPDC_RST_DRV 1'b1
`define CGPDC_BLANK_ZERO 8'h00
`define CGPDC_BLANK_DRV 8'h01
`define CGPDC_BLANK_OSC 8'h02
`define CGPDC_BLANK_REFF 8'h30
`define CGPDC_BLANK_IOCFG 8'h03
`define CGPDC_NVM_WORDS 18
// ****************************************************************
// timing
// ****************************************************************
`define CGPDC_CLK_NS 8
`define CGPDC_ALIGN_NS 80
`define CGPDC_ALIGN_CYC ((`CGPDC_ALIGN_NS + `CGPDC_CLK_NS - 1) / `CGPDC_CLK_NS)
`endif

/* verilog/cgpdc_pkg.sv */
// ****************************************************************
// shared types
// ****************************************************************
package cgpdc_pkg;
    // one register write, from host or from the image loader
    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [7:0] data;
    } cgpdc_wr_s;
    // sequencer states
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_LOAD = 2'b01,
        ST_ALIGN = 2'b10,
        ST_RUN = 2'b11
    } cgpdc_state_e;
endpackage

/* verilog/cgpdc_nvm_loader.sv */
`timescale 1ns/1ns
`include "cgpdc_map.svh"
module cgpdc_nvm_loader
    import cgpdc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o,
    output cgpdc_wr_s wr_o
);
    // ****************************************************************
    // nonvolatile configuration memory, blank image
    // ****************************************************************
    localparam int NW = `CGPDC_NVM_WORDS;
    localparam int IW = $clog2(NW);
    localparam logic [IW-1:0] LAST = IW'(NW - 1);
    localparam logic [23:0] NVM_MEM [NW] = '{
        {`CGPDC_ADDR_SOFT, `CGPDC_BLANK_ZERO},
        {`CGPDC_ADDR_PDN, `CGPDC_BLANK_ZERO},
        {`CGPDC_ADDR_DRV0A, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV0, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV1, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV2, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV3, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV4, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV5, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV6, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV7, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV8, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV9, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_DRV9A, `CGPDC_BLANK_DRV},
        {`CGPDC_ADDR_ALL, `CGPDC_BLANK_ZERO},
        {`CGPDC_ADDR_OSC, `CGPDC_BLANK_OSC},
        {`CGPDC_ADDR_REFF, `CGPDC_BLANK_REFF},
        {`CGPDC_ADDR_IOCFG, `CGPDC_BLANK_IOCFG}
    };

    logic busy_r;
    logic [IW-1:0] idx_r;

    // walk the image one word per cycle after a start pulse
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            idx_r <= '0;
        end else if (start_i) begin
            busy_r <= 1'b1;
            idx_r <= '0;
        end else if (busy_r) begin
            busy_r <= (idx_r != LAST);
            idx_r <= (idx_r == LAST) ? '0 : IW'(idx_r + 1'b1);
        end
    end

    // current word as a write strobe
    assign busy_o = busy_r;
    assign wr_o = '{en: busy_r, addr: NVM_MEM[idx_r][23:8], data: NVM_MEM[idx_r][7:0]};
endmodule // cgpdc_nvm_loader

/* verilog/cgpdc_top.sv */
`timescale 1ns/1ns
`include "cgpdc_map.svh"
module cgpdc_top
    import cgpdc_pkg::*;
#(
    parameter int ALIGN_CYC = `CGPDC_ALIGN_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic external_reset_pin_n_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic core_en_o,
    output logic [`CGPDC_N_DRV-1:0] drv_en_o,
    output logic osc_run_o,
    output logic align_o,
    output logic loading_o,
    output logic [7:0] ref_freq_mhz_o,
    output logic ref_is_xtal_o,
    output logic io_1v8_o
);
    // ****************************************************************
    // constants and checks
    // ****************************************************************
    localparam int ND = `CGPDC_N_DRV;
    localparam int CW = $clog2(ALIGN_CYC + 1);
    localparam logic [CW-1:0] ALIGN_LAST = CW'(ALIGN_CYC - 1);
    localparam logic [15:0] DRV_ADDR [ND] = '{
        `CGPDC_ADDR_DRV0A, `CGPDC_ADDR_DRV0, `CGPDC_ADDR_DRV1, `CGPDC_ADDR_DRV2,
        `CGPDC_ADDR_DRV3, `CGPDC_ADDR_DRV4, `CGPDC_ADDR_DRV5, `CGPDC_ADDR_DRV6,
        `CGPDC_ADDR_DRV7, `CGPDC_ADDR_DRV8, `CGPDC_ADDR_DRV9, `CGPDC_ADDR_DRV9A
    };

    generate
        if (ALIGN_CYC < 8 || ALIGN_CYC > 255) begin : g_bad_align
            $error("ALIGN_CYC must lie in 8..255");
        end
    endgenerate

    // ****************************************************************
    // state and register storage
    // ****************************************************************
    cgpdc_state_e state_r;
    cgpdc_state_e state_nxt;
    logic [CW-1:0] align_cnt_r;
    logic [7:0] page_r;
    logic soft_rst_r;
    logic soft_rst_nxt;
    logic hard_pend_r;
    logic hard_pend_nxt;
    logic dev_pdn_r;
    logic [ND-1:0] drv_off_r;
    logic all_off_r;
    logic osc_en_r;
    logic [7:0] ref_freq_r;
    logic io_1v8_r;
    logic xtal_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic core_en_r;
    logic [ND-1:0] drv_en_r;
    logic [ND-1:0] drv_en_nxt;
    logic osc_run_r;
    logic align_r;
    logic loading_r;

    // ****************************************************************
    // write path: loader owns the port while the image streams in
    // ****************************************************************
    logic ld_start;
    logic ld_busy;
    cgpdc_wr_s ld_wr;
    cgpdc_wr_s wr;
    logic host_ok;
    logic host_pg_wr;
    logic [15:0] host_addr;
    logic align_end;

    assign ld_start = (state_r == ST_BOOT) && external_reset_pin_n_i;

    cgpdc_nvm_loader u_loader (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(ld_start),
        .busy_o(ld_busy),
        .wr_o(ld_wr)
    );

    // host accesses land on the selected page; page select is on every page
    assign host_ok = (state_r == ST_ALIGN) || (state_r == ST_RUN);
    assign host_addr = {page_r, reg_addr_i};
    assign host_pg_wr = reg_wr_i && host_ok && (reg_addr_i == `CGPDC_PAGE_LOC);
    assign wr = ld_wr.en ? ld_wr :
        cgpdc_wr_s'{en: reg_wr_i && host_ok && !host_pg_wr, addr: host_addr, data: reg_wdata_i};
    assign align_end = (state_r == ST_ALIGN) && (align_cnt_r == ALIGN_LAST);

    // write decode
    logic hit_soft;
    logic hit_pdn;
    logic hit_all;
    logic hit_osc;
    logic hit_reff;
    logic hit_io;
    logic [ND-1:0] hit_drv;
    assign hit_soft = wr.en && (wr.addr == `CGPDC_ADDR_SOFT);
    assign hit_pdn = wr.en && (wr.addr == `CGPDC_ADDR_PDN);
    assign hit_all = wr.en && (wr.addr == `CGPDC_ADDR_ALL);
    assign hit_osc = wr.en && (wr.addr == `CGPDC_ADDR_OSC);
    assign hit_reff = wr.en && (wr.addr == `CGPDC_ADDR_REFF);
    assign hit_io = wr.en && (wr.addr == `CGPDC_ADDR_IOCFG);

    // soft reset clears itself at the end of alignment; a new write wins
    assign soft_rst_nxt = hit_soft ? wr.data[`CGPDC_BIT_SOFT] :
        (align_end ? 1'b0 : soft_rst_r);
    // hard request is dropped once the sequencer reboots; a set wins
    assign hard_pend_nxt = (hit_pdn && wr.data[`CGPDC_BIT_HARD]) ||
        (hard_pend_r && (state_r != ST_BOOT));

    // ****************************************************************
    // control registers
    // ****************************************************************
    // page, reset requests and device power-down
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            page_r <= `CGPDC_RST_PAGE;
            soft_rst_r <= 1'b0;
            hard_pend_r <= 1'b0;
            dev_pdn_r <= 1'b0;
        end else begin
            page_r <= host_pg_wr ? reg_wdata_i : page_r;
            soft_rst_r <= soft_rst_nxt;
            hard_pend_r <= hard_pend_nxt;
            dev_pdn_r <= hit_pdn ? wr.data[`CGPDC_BIT_DEVPDN] : dev_pdn_r;
        end
    end

    // all-off, oscillator and reference configuration, blank values at reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            all_off_r <= 1'b0;
            osc_en_r <= 1'b1;
            ref_freq_r <= `CGPDC_BLANK_REFF;
            io_1v8_r <= 1'b1;
            xtal_r <= 1'b1;
        end else begin
            all_off_r <= hit_all ? wr.data[`CGPDC_BIT_ALL] : all_off_r;
            osc_en_r <= hit_osc ? wr.data[`CGPDC_BIT_OSC] : osc_en_r;
            ref_freq_r <= hit_reff ? wr.data : ref_freq_r;
            io_1v8_r <= hit_io ? wr.data[`CGPDC_BIT_IO1V8] : io_1v8_r;
            xtal_r <= hit_io ? wr.data[`CGPDC_BIT_XTAL] : xtal_r;
        end
    end

    // one off bit per driver, bit 0 of its own register
    logic [ND-1:0] rd_drv;
    genvar gi;
    generate
        for (gi = 0; gi < ND; gi++) begin : g_drv
            assign hit_drv[gi] = wr.en && (wr.addr == DRV_ADDR[gi]);
            assign rd_drv[gi] = (host_addr == DRV_ADDR[gi]);
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    drv_off_r[gi] <= `CGPDC_RST_DRV;
                end else if (hit_drv[gi]) begin
                    drv_off_r[gi] <= wr.data[`CGPDC_BIT_DRV];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // read path, one byte per register, unused bits zero
    // ****************************************************************
    logic rd_page;
    logic [7:0] rd_byte;
    assign rd_page = (reg_addr_i == `CGPDC_PAGE_LOC);
    assign rd_byte = rd_page ? page_r : (
        ({8{host_addr == `CGPDC_ADDR_SOFT}} & (8'(soft_rst_r) << `CGPDC_BIT_SOFT)) |
        ({8{host_addr == `CGPDC_ADDR_PDN}} & ((8'(hard_pend_r) << `CGPDC_BIT_HARD) |
            (8'(dev_pdn_r) << `CGPDC_BIT_DEVPDN))) |
        ({8{|rd_drv}} & (8'(|(rd_drv & drv_off_r)) << `CGPDC_BIT_DRV)) |
        ({8{host_addr == `CGPDC_ADDR_ALL}} & (8'(all_off_r) << `CGPDC_BIT_ALL)) |
        ({8{host_addr == `CGPDC_ADDR_OSC}} & (8'(osc_en_r) << `CGPDC_BIT_OSC)) |
        ({8{host_addr == `CGPDC_ADDR_REFF}} & ref_freq_r) |
        ({8{host_addr == `CGPDC_ADDR_IOCFG}} & ((8'(xtal_r) << `CGPDC_BIT_XTAL) |
            (8'(io_1v8_r) << `CGPDC_BIT_IO1V8))));

    // read answer one cycle after the strobe, in every state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_r <= `CGPDC_BLANK_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= reg_rd_i ? rd_byte : rdata_r;
            rvalid_r <= reg_rd_i;
        end
    end

    // ****************************************************************
    // sequencer: boot, image load, alignment, run
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_BOOT: state_nxt = ST_LOAD;
            ST_LOAD: state_nxt = ld_busy ? ST_LOAD : ST_ALIGN;
            ST_ALIGN: state_nxt = align_end ? ST_RUN : ST_ALIGN;
            ST_RUN: begin
                if (hard_pend_r) begin
                    state_nxt = ST_BOOT;
                end else if (soft_rst_r) begin
                    state_nxt = ST_ALIGN;
                end
            end
            default: state_nxt = ST_BOOT;
        endcase
        if (!external_reset_pin_n_i) begin
            state_nxt = ST_BOOT;
        end
    end

    // state and alignment counter
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= ST_BOOT;
            align_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            align_cnt_r <= (state_r == ST_ALIGN) ? CW'(align_cnt_r + 1'b1) : '0;
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    // a driver runs only in run state with its own bit, all-off and device pdn low
    assign drv_en_nxt = (state_r == ST_RUN && !dev_pdn_r && !all_off_r) ?
        ~drv_off_r : '0;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            core_en_r <= 1'b0;
            drv_en_r <= '0;
            osc_run_r <= 1'b0;
            align_r <= 1'b0;
            loading_r <= 1'b0;
        end else begin
            core_en_r <= !dev_pdn_r;
            drv_en_r <= drv_en_nxt;
            osc_run_r <= osc_en_r && !dev_pdn_r;
            align_r <= (state_r != ST_RUN);
            loading_r <= (state_r == ST_LOAD);
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;
    assign core_en_o = core_en_r;
    assign drv_en_o = drv_en_r;
    assign osc_run_o = osc_run_r;
    assign align_o = align_r;
    assign loading_o = loading_r;
    assign ref_freq_mhz_o = ref_freq_r;
    assign ref_is_xtal_o = xtal_r;
    assign io_1v8_o = io_1v8_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_pdn_core;
        dev_pdn_r |=> !core_en_o && (drv_en_o == '0);
    endproperty
    a_pdn_core: assert property (p_pdn_core) else $error("core live in power-down");
    property p_pdn_serial;
        (dev_pdn_r && reg_rd_i) |=> reg_rvalid_o;
    endproperty
    a_pdn_serial: assert property (p_pdn_serial) else $error("no read in power-down");
    property p_drv_off;
        ##1 ((drv_en_o & $past(drv_off_r)) == '0);
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("driver on with off bit");
    property p_all_off;
        all_off_r |=> (drv_en_o == '0);
    endproperty
    a_all_off: assert property (p_all_off) else $error("driver on with all-off");
    property p_osc_stop;
        (state_r == ST_RUN && reg_wr_i && reg_addr_i == 8'(`CGPDC_ADDR_OSC) && page_r ==
            8'(`CGPDC_ADDR_OSC >> 8) && !reg_wdata_i[`CGPDC_BIT_OSC]) |-> ##2 !osc_run_o;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped");
    property p_soft_align;
        (state_r == ST_RUN && soft_rst_r && !hard_pend_r) |=> ##1 align_o [*8];
    endproperty
    a_soft_align: assert property (p_soft_align) else $error("soft reset no align");
    property p_pin_align;
        !external_reset_pin_n_i |=> ##1 align_o;
    endproperty
    a_pin_align: assert property (p_pin_align) else $error("pin reset no align");
    property p_hard_load;
        (state_r == ST_RUN && hard_pend_r) |=> ##[1:3] loading_o;
    endproperty
    a_hard_load: assert property (p_hard_load) else $error("hard reset no reload");
    property p_blank_off;
        (state_r == ST_LOAD && !ld_busy) |=> (&drv_off_r) && (drv_en_o == '0);
    endproperty
    a_blank_off: assert property (p_blank_off) else $error("blank image drives on");
    property p_blank_ref;
        (state_r == ST_LOAD && !ld_busy) |=> (ref_freq_r == `CGPDC_BLANK_REFF) &&
            xtal_r && io_1v8_r;
    endproperty
    a_blank_ref: assert property (p_blank_ref) else $error("blank reference wrong");
    property p_page;
        host_pg_wr |=> (page_r == $past(reg_wdata_i));
    endproperty
    a_page: assert property (p_page) else $error("page select not taken");
    property p_byte;
        (reg_rd_i && |rd_drv && !rd_page) |=> (reg_rdata_o[7:1] == 7'h00);
    endproperty
    a_byte: assert property (p_byte) else $error("unused bits not zero");
    property p_drv_on;
        (state_r == ST_RUN && !dev_pdn_r && !all_off_r) |=> (drv_en_o == ~$past(drv_off_r));
    endproperty
    a_drv_on: assert property (p_drv_on) else $error("driver state wrong");

    c_soft: cover property (state_r == ST_RUN && soft_rst_r ##1 state_r == ST_ALIGN);
    c_hard: cover property (state_r == ST_RUN && hard_pend_r ##3 loading_o);
    c_pin: cover property (!external_reset_pin_n_i ##1 external_reset_pin_n_i);
    c_run: cover property (drv_en_o != '0);
endmodule // cgpdc_top

/* dv/cgpdc_host.sv */
`timescale 1ns/1ns
// ****************************************************************
// host controller model on the byte register port
// ****************************************************************
module cgpdc_host (
    input wire logic core_clk_i,
    input wire logic reg_rvalid_i,
    input wire logic [7:0] reg_rdata_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // one strobe cycle; the idle bus shows the inverse of the last value
    task automatic cyc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        reg_wr_o = wr;
        reg_rd_o = ~wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge core_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    // page select first, so the byte address lands on the right page
    task automatic wr16(input logic [15:0] a, input logic [7:0] d);
        cyc(1'b1, 8'h01, a[15:8]);
        cyc(1'b1, a[7:0], d);
    endtask
    // read answer is taken in the cycle after the strobe edge
    task automatic rd16(input logic [15:0] a, output logic [7:0] d);
        cyc(1'b1, 8'h01, a[15:8]);
        cyc(1'b0, a[7:0], 8'h00);
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
    endtask
endmodule // cgpdc_host

/* dv/tb.sv */
`timescale 1ns/1ns
// ****************************************************************
// testbench top
// ****************************************************************
module tb;
    import cgpdc_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pin_n = 1'b1;
    logic wr, rd, rvalid, core_en, osc_run, align, loading, xtal, io_1v8;
    logic [7:0] addr, wdata, rdata, ref_freq, d;
    logic [11:0] drv_en;
    int mismatches = 0;
    int n_checks = 0;
    logic [15:0] drv_tbl [12] = '{16'h0103, 16'h0108, 16'h010D, 16'h0112, 16'h0117,
        16'h011C, 16'h0121, 16'h0126, 16'h012B, 16'h0130, 16'h0135, 16'h013A};
    always #4 core_clk_i = ~core_clk_i;
    cgpdc_top #(.ALIGN_CYC(8)) u_cgpdc_top (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .external_reset_pin_n_i(pin_n), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .core_en_o(core_en), .drv_en_o(drv_en), .osc_run_o(osc_run), .align_o(align),
        .loading_o(loading), .ref_freq_mhz_o(ref_freq), .ref_is_xtal_o(xtal),
        .io_1v8_o(io_1v8));
    cgpdc_host u_cgpdc_host (.core_clk_i(core_clk_i), .reg_rvalid_i(rvalid),
        .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata));
    // compare one value, report at once on a mismatch
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
    // bounded wait for the alignment flag to reach a level
    task automatic wait_align(input logic v, input int lim);
        int n;
        n = 0;
        while (align !== v && n < lim) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk(12'(align), 12'(v));
    endtask
    task automatic realign();
        wait_align(1'b1, 5);
        wait_align(1'b0, 60);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        u_cgpdc_host.rd16(a, d);
        chk(12'(d), 12'(exp));
    endtask
    // blank part after power-up
    task automatic t_blank();
        realign();
        chk(drv_en, 12'h000);
        chk(12'(ref_freq), 12'h030);
        chk(12'({xtal, io_1v8}), 12'h003);
        chk(12'({core_en, osc_run}), 12'h003);
        rdchk(16'h0108, 8'h01);
    endtask
    // load drivers, then each single off bit and the all-off bit
    task automatic t_drivers();
        for (int i = 0; i < 12; i++) u_cgpdc_host.wr16(drv_tbl[i], 8'h00);
        settle();
        chk(drv_en, 12'hFFF);
        for (int i = 0; i < 12; i++) begin
            u_cgpdc_host.wr16(drv_tbl[i], 8'h01);
            settle();
            chk(drv_en, ~(12'h001 << i));
            u_cgpdc_host.wr16(drv_tbl[i], 8'h00);
        end
        u_cgpdc_host.wr16(16'h0145, 8'h01);
        settle();
        chk(drv_en, 12'h000);
        u_cgpdc_host.wr16(16'h0145, 8'h00);
        settle();
        chk(drv_en, 12'hFFF);
    endtask
    // device power-down keeps the register port alive
    task automatic t_power();
        u_cgpdc_host.wr16(16'h001E, 8'h01);
        settle();
        chk(12'({core_en, osc_run}), 12'h000);
        chk(drv_en, 12'h000);
        rdchk(16'h001E, 8'h01);
        rdchk(16'h0108, 8'h00);
        u_cgpdc_host.wr16(16'h001E, 8'h00);
        settle();
        chk(drv_en, 12'hFFF);
    endtask
    // oscillator enable, active low power-down
    task automatic t_osc();
        u_cgpdc_host.wr16(16'h090E, 8'h00);
        settle();
        chk(12'(osc_run), 12'h000);
        rdchk(16'h090E, 8'h00);
        u_cgpdc_host.wr16(16'h090E, 8'h02);
        settle();
        chk(12'(osc_run), 12'h001);
    endtask
    // soft reset keeps settings, hard reset and pin reload the image
    task automatic t_resets();
        u_cgpdc_host.wr16(16'h001C, 8'h01);
        wait_align(1'b1, 5);
        chk(drv_en, 12'h000);
        wait_align(1'b0, 60);
        settle();
        chk(drv_en, 12'hFFF);
        chk(12'({ref_freq, xtal, io_1v8}), 12'h064);
        rdchk(16'h001C, 8'h00);
        u_cgpdc_host.wr16(16'h001E, 8'h02);
        wait_align(1'b1, 5);
        @(posedge core_clk_i);
        #1;
        chk(12'(loading), 12'h001);
        wait_align(1'b0, 60);
        chk(12'({ref_freq, xtal, io_1v8}), 12'h0C3);
        chk(drv_en, 12'h000);
        rdchk(16'h0108, 8'h01);
        u_cgpdc_host.wr16(16'h0103, 8'h00);
        settle();
        chk(drv_en, 12'h001);
        pin_n = 1'b0;
        wait_align(1'b1, 5);
        repeat (3) @(posedge core_clk_i);
        #1;
        pin_n = 1'b1;
        wait_align(1'b0, 60);
        chk(drv_en, 12'h000);
    endtask
    // page readback and an unmapped place
    task automatic t_map();
        rdchk(16'h0901, 8'h09);
        rdchk(16'h0150, 8'h00);
        u_cgpdc_host.wr16(16'h0940, 8'h19);
        u_cgpdc_host.wr16(16'h0941, 8'h00);
        settle();
        chk(12'({ref_freq, xtal, io_1v8}), 12'h064);
        rdchk(16'h0941, 8'h00);
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        t_blank();
        t_drivers();
        t_power();
        t_osc();
        t_map();
        t_resets();
        test_done();
    end
    // cut a hang short
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
endmodule // tb
